// file: inc/txu_defines.vh
// field positions, codes and sizes for the transmit buffer unpacker
`ifndef TXU_DEFINES_VH
`define TXU_DEFINES_VH

// first command word fields
`define TXU_A_DONE      31
`define TXU_A_ALIGN_HI  25
`define TXU_A_ALIGN_LO  24
`define TXU_A_OFF_HI    20
`define TXU_A_OFF_LO    16
`define TXU_A_FIRST     13
`define TXU_A_LAST      12
`define TXU_A_SIZE_HI   10
`define TXU_A_SIZE_LO   0

// second command word fields
`define TXU_B_TAG_HI    31
`define TXU_B_TAG_LO    16
`define TXU_B_CSUM      14
`define TXU_B_CRC_DIS   13
`define TXU_B_PAD_DIS   12
`define TXU_B_LEN_HI    10
`define TXU_B_LEN_LO    0

// end alignment codes
`define TXU_ALIGN_4     2'h0
`define TXU_ALIGN_16    2'h1
`define TXU_ALIGN_32    2'h2

// dword masks used to round a word count up to the alignment
`define TXU_AMASK_4     12'h000
`define TXU_AMASK_16    12'h003
`define TXU_AMASK_32    12'h007

// buffering
`define TXU_FIFO_DEPTH  8
`define TXU_FIFO_AW     3

`endif

// file: hdl/txu_fifo.v
// small synchronous fifo with registered ready and registered read port
`include "txu_defines.vh"

module txu_fifo #(
    parameter WIDTH = 38,
    parameter DEPTH = `TXU_FIFO_DEPTH,
    parameter AW    = `TXU_FIFO_AW
) (
    // clock and reset
    input  wire             mclk,
    input  wire             nrst,
    // write side
    input  wire             wr_valid,
    input  wire [WIDTH-1:0] wr_data,
    output reg              wr_ready_q,
    // read side
    output reg              rd_valid_q,
    output reg  [WIDTH-1:0] rd_data_q,
    input  wire             rd_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr_q;
    reg [AW-1:0]    rptr_q;
    reg [AW:0]      count_q;
    reg [AW:0]      count_d;
    wire            push;
    wire            pop;

    assign push = wr_valid & wr_ready_q;
    // the output register reloads when empty or when the reader takes it
    assign pop  = (count_q != {(AW+1){1'h0}}) & (~rd_valid_q | rd_ready);

    // occupancy, ready is registered so the source sees honest full
    always @* begin
        count_d = count_q;
        if (push & ~pop)
            count_d = count_q + 1'h1;
        else if (pop & ~push)
            count_d = count_q - 1'h1;
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wptr_q     <= {AW{1'h0}};
            rptr_q     <= {AW{1'h0}};
            count_q    <= {(AW+1){1'h0}};
            wr_ready_q <= 1'h1;
            rd_valid_q <= 1'h0;
            rd_data_q  <= {WIDTH{1'h0}};
        end else begin
            count_q    <= count_d;
            wr_ready_q <= (count_d < DEPTH);
            if (push) begin
                wptr_q <= (wptr_q == DEPTH - 1) ? {AW{1'h0}}
                                                : wptr_q + 1'h1;
            end
            if (pop) begin
                rd_data_q  <= mem[rptr_q];
                rd_valid_q <= 1'h1;
                rptr_q     <= (rptr_q == DEPTH - 1) ? {AW{1'h0}}
                                                    : rptr_q + 1'h1;
            end else if (rd_ready) begin
                rd_valid_q <= 1'h0;
            end
        end
    end

    // storage has no reset, only written entries are ever read
    always @(posedge mclk) begin
        if (push)
            mem[wptr_q] <= wr_data;
    end
endmodule // txu_fifo

// file: hdl/txu_unpacker.v
// transmit buffer command unpacker: strips command words and padding
//
// Notes on behaviour
// - first-command bit 13 opens a new packet with this buffer
// - first-command bit 12 closes the packet after this buffer's payload
// - buffer size, offset and end alignment give the trailing pad dwords
// - running sum of buffer sizes checked against packet length
// - second-command bits 31:16 copied out as the packet tag
// - checksum only if bit 14, first segment and global enable set
// - second-command bit 13 suppresses the automatic crc
// - bit 12 disables short frame padding and forces crc on
// - packet length in second-command bits 10:0, mismatch flags error
// - payload starts after the command words and any skipped offset dwords
// - low two offset bits pick the first valid byte lane
// - offset bits above the byte lane skip up to seven dwords
// - payload contiguous, unused tail bytes of last dword withheld
// - host pads to 4, 16 or 32 bytes, device strips it
// - first-command bit 31 raises loaded flag after the buffer
// - alignment code 00 4-byte, 01 16-byte, 10 32-byte, 11 reserved
// - second command word present only on first-segment buffers
`include "txu_defines.vh"

module txu_unpacker #(
    parameter DEPTH = `TXU_FIFO_DEPTH,
    parameter AW    = `TXU_FIFO_AW
) (
    // clock and reset
    input  wire        mclk,
    input  wire        nrst,
    // host write stream
    input  wire        in_valid,
    input  wire [31:0] in_data,
    output wire        in_ready,
    // mac side payload stream
    output wire        mac_valid,
    output wire [31:0] mac_data,
    output wire [3:0]  mac_be,
    output wire        mac_sop,
    output wire        mac_eop,
    input  wire        mac_ready,
    // per packet controls
    output reg  [15:0] pkt_tag_q,
    output reg         csum_req_q,
    output reg         crc_add_dis_q,
    output reg         pad_dis_q,
    // configuration and status
    input  wire        checksum_offload_global_enable,
    output reg         transmit_error_flag_q,
    input  wire        error_clr,
    output reg         buffer_loaded_flag_q,
    input  wire        loaded_clr
);
    // unpacker states
    localparam [2:0] ST_CMDA = 3'h0;
    localparam [2:0] ST_CMDB = 3'h1;
    localparam [2:0] ST_SKIP = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_PAD  = 3'h4;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [11:0] skip_q;
    reg  [11:0] skip_d;
    reg  [11:0] data_q;
    reg  [11:0] data_d;
    reg  [11:0] pad_q;
    reg  [11:0] pad_d;
    reg  [3:0]  first_be_q;
    reg  [3:0]  last_be_q;
    reg         first_word_q;
    reg         last_seg_q;
    reg         done_req_q;
    reg         pkt_start_q;
    reg  [11:0] sum_q;
    reg  [10:0] len_q;
    reg         in_pkt_q;
    reg         err_set;
    reg         loaded_set;

    wire        take;
    wire [10:0] a_size;
    wire [4:0]  a_off;
    wire [1:0]  a_align;
    wire [11:0] span;
    wire [11:0] words;
    wire [11:0] amask;
    wire [11:0] total;
    wire [11:0] n_skip;
    wire [11:0] n_data;
    wire [11:0] n_pad;
    wire [1:0]  end_lane;
    wire [11:0] sum_next;
    wire        fifo_wr;
    wire [3:0]  be_now;
    wire        eop_now;
    wire [37:0] fifo_in;
    wire [37:0] fifo_out;

    assign take = in_valid & in_ready;

    // first command word decode
    assign a_size  = in_data[`TXU_A_SIZE_HI:`TXU_A_SIZE_LO];
    assign a_off   = in_data[`TXU_A_OFF_HI:`TXU_A_OFF_LO];
    assign a_align = in_data[`TXU_A_ALIGN_HI:`TXU_A_ALIGN_LO];

    // dword budget of one buffer, all widths kept at 12 bits
    assign span   = {1'h0, a_size} + {7'h00, a_off};
    assign words  = (span + 12'h003) >> 2;
    assign amask  = (a_align == `TXU_ALIGN_32) ? `TXU_AMASK_32 :
                    (a_align == `TXU_ALIGN_16) ? `TXU_AMASK_16 :
                                                 `TXU_AMASK_4;
    assign total  = (words + amask) & ~amask;
    assign n_skip = {9'h000, a_off[4:2]};
    assign n_data = ({1'h0, a_size} + {10'h000, a_off[1:0]}
                     + 12'h003) >> 2;
    assign n_pad  = total - n_skip - n_data;
    assign end_lane = a_size[1:0] + a_off[1:0];

    // running byte count of the packet so far
    assign sum_next = in_data[`TXU_A_FIRST] ? {1'h0, a_size}
                                            : sum_q + {1'h0, a_size};

    // payload word handling
    assign fifo_wr = take & (state_q == ST_DATA);
    assign eop_now = last_seg_q & (data_q == 12'h001);
    assign be_now  = (first_word_q ? first_be_q : 4'hF)
                   & ((data_q == 12'h001) ? last_be_q : 4'hF);
    assign fifo_in = {pkt_start_q & first_word_q, eop_now, be_now, in_data};

    // next state and counters
    always @* begin
        state_d = state_q;
        skip_d  = skip_q;
        data_d  = data_q;
        pad_d   = pad_q;
        if (take) begin
            case (state_q)
                ST_CMDA: begin
                    skip_d = n_skip;
                    data_d = n_data;
                    pad_d  = n_pad;
                    if (in_data[`TXU_A_FIRST])
                        state_d = ST_CMDB;
                    else if (n_skip != 12'h000)
                        state_d = ST_SKIP;
                    else if (n_data != 12'h000)
                        state_d = ST_DATA;
                    else if (n_pad != 12'h000)
                        state_d = ST_PAD;
                    else
                        state_d = ST_CMDA;
                end
                ST_CMDB: begin
                    if (skip_q != 12'h000)
                        state_d = ST_SKIP;
                    else if (data_q != 12'h000)
                        state_d = ST_DATA;
                    else if (pad_q != 12'h000)
                        state_d = ST_PAD;
                    else
                        state_d = ST_CMDA;
                end
                ST_SKIP: begin
                    skip_d = skip_q - 12'h001;
                    if (skip_q == 12'h001)
                        state_d = (data_q != 12'h000) ? ST_DATA :
                                  (pad_q != 12'h000) ? ST_PAD : ST_CMDA;
                end
                ST_DATA: begin
                    data_d = data_q - 12'h001;
                    if (data_q == 12'h001)
                        state_d = (pad_q != 12'h000) ? ST_PAD : ST_CMDA;
                end
                ST_PAD: begin
                    pad_d = pad_q - 12'h001;
                    if (pad_q == 12'h001)
                        state_d = ST_CMDA;
                end
                default: state_d = ST_CMDA;
            endcase
        end
    end

    // events that set the sticky flags, loaded when a buffer is finished, error at its command words
    always @* begin
        err_set    = 1'h0;
        loaded_set = 1'h0;
        // a first buffer with no words beyond its second command ends here
        if (take && state_q != ST_CMDA && state_d == ST_CMDA)
            loaded_set = done_req_q;
        if (take && state_q == ST_CMDA && state_d == ST_CMDA)
            loaded_set = in_data[`TXU_A_DONE];
        // length check on the closing buffer, against the packet length
        if (take && state_q == ST_CMDA && in_data[`TXU_A_LAST]
            && !in_data[`TXU_A_FIRST])
            err_set = (sum_next != {1'h0, len_q});
        if (take && state_q == ST_CMDB && last_seg_q)
            err_set = (sum_q != {1'h0,
                       in_data[`TXU_B_LEN_HI:`TXU_B_LEN_LO]});
        // a buffer without an opening packet cannot be counted
        if (take && state_q == ST_CMDA && !in_data[`TXU_A_FIRST]
            && !in_pkt_q)
            err_set = 1'h1;
    end

    // sequencing registers
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q      <= ST_CMDA;
            skip_q       <= 12'h000;
            data_q       <= 12'h000;
            pad_q        <= 12'h000;
            first_be_q   <= 4'hF;
            last_be_q    <= 4'hF;
            first_word_q <= 1'h0;
            last_seg_q   <= 1'h0;
            done_req_q   <= 1'h0;
            pkt_start_q  <= 1'h0;
            sum_q        <= 12'h000;
            len_q        <= 11'h000;
            in_pkt_q     <= 1'h0;
        end else begin
            state_q <= state_d;
            skip_q  <= skip_d;
            data_q  <= data_d;
            pad_q   <= pad_d;
            if (take && state_q == ST_CMDA) begin
                // byte lane masks for the first and last payload dwords
                first_be_q   <= 4'hF << a_off[1:0];
                last_be_q    <= (end_lane == 2'h0) ? 4'hF :
                                (4'hF >> (3'h4 - {1'h0, end_lane}));
                first_word_q <= 1'h1;
                last_seg_q   <= in_data[`TXU_A_LAST];
                done_req_q   <= in_data[`TXU_A_DONE];
                pkt_start_q  <= in_data[`TXU_A_FIRST];
                sum_q        <= sum_next;
                in_pkt_q     <= ~in_data[`TXU_A_LAST];
            end
            if (take && state_q == ST_CMDB)
                len_q <= in_data[`TXU_B_LEN_HI:`TXU_B_LEN_LO];
            if (fifo_wr)
                first_word_q <= 1'h0;
        end
    end

    // per packet controls latched from the second command word
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pkt_tag_q     <= 16'h0000;
            csum_req_q    <= 1'h0;
            crc_add_dis_q <= 1'h0;
            pad_dis_q     <= 1'h0;
        end else if (take && state_q == ST_CMDB) begin
            pkt_tag_q     <= in_data[`TXU_B_TAG_HI:`TXU_B_TAG_LO];
            // second word only exists on first segments, so the flag holds
            csum_req_q    <= in_data[`TXU_B_CSUM]
                           & checksum_offload_global_enable;
            // disabling pad forces the crc back on
            crc_add_dis_q <= in_data[`TXU_B_CRC_DIS]
                           & ~in_data[`TXU_B_PAD_DIS];
            pad_dis_q     <= in_data[`TXU_B_PAD_DIS];
        end
    end

    // sticky flags, a set in the clearing cycle wins
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            transmit_error_flag_q <= 1'h0;
            buffer_loaded_flag_q  <= 1'h0;
        end else begin
            if (err_set)
                transmit_error_flag_q <= 1'h1;
            else if (error_clr)
                transmit_error_flag_q <= 1'h0;
            if (loaded_set)
                buffer_loaded_flag_q <= 1'h1;
            else if (loaded_clr)
                buffer_loaded_flag_q <= 1'h0;
        end
    end

    // payload buffer; its registered ready stalls the whole host stream,
    // command words included, which costs nothing and keeps ready a flop
    txu_fifo #(
        .WIDTH (38),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .mclk       (mclk),
        .nrst       (nrst),
        .wr_valid   (fifo_wr),
        .wr_data    (fifo_in),
        .wr_ready_q (in_ready),
        .rd_valid_q (mac_valid),
        .rd_data_q  (fifo_out),
        .rd_ready   (mac_ready)
    );

    assign mac_data = fifo_out[31:0];
    assign mac_be   = fifo_out[35:32];
    assign mac_eop  = fifo_out[36];
    assign mac_sop  = fifo_out[37];
endmodule // txu_unpacker

// file: tb/txu_monitor.sv
// port checker for the transmit buffer unpacker
module txu_monitor (
    // clock and reset
    input logic        mclk,
    input logic        nrst,
    // host and mac streams
    input logic        in_valid,
    input logic        in_ready,
    input logic        mac_valid,
    input logic [31:0] mac_data,
    input logic [3:0]  mac_be,
    input logic        mac_sop,
    input logic        mac_eop,
    input logic        mac_ready,
    // controls and flags
    input logic [15:0] pkt_tag_q,
    input logic        csum_req_q,
    input logic        crc_add_dis_q,
    input logic        pad_dis_q,
    input logic        checksum_offload_global_enable,
    input logic        transmit_error_flag_q,
    input logic        error_clr,
    input logic        buffer_loaded_flag_q,
    input logic        loaded_clr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // a host word went in one or two edges back
    sequence s_took;
        ($past(in_valid) && $past(in_ready)) ||
        ($past(in_valid, 2) && $past(in_ready, 2));
    endsequence
    sequence s_end_taken;
        mac_valid && mac_ready && mac_eop;
    endsequence

    a_mac_hold: assert property (
        mac_valid && !mac_ready |=> mac_valid &&
        $stable({mac_data, mac_be, mac_sop, mac_eop}))
        else $error("mac word changed while stalled");
    a_be_contig: assert property (
        mac_valid |-> mac_be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6,
                                     4'h7, 4'h8, 4'hC, 4'hE, 4'hF})
        else $error("byte enables not one contiguous run");
    a_pad_forces_crc: assert property (
        pad_dis_q |-> !crc_add_dis_q)
        else $error("crc dropped while padding is off");
    a_csum_gate: assert property (
        $rose(csum_req_q) |-> $past(checksum_offload_global_enable) ||
        $past(checksum_offload_global_enable, 2))
        else $error("checksum requested with offload off");
    a_tag_source: assert property (
        $changed(pkt_tag_q) |-> s_took)
        else $error("tag changed without a host word");
    a_ctl_source: assert property (
        $changed({csum_req_q, crc_add_dis_q, pad_dis_q}) |-> s_took)
        else $error("controls changed without a host word");
    a_err_sticky: assert property (
        transmit_error_flag_q && !error_clr |=> transmit_error_flag_q)
        else $error("error flag fell without a clear");
    a_err_source: assert property (
        $rose(transmit_error_flag_q) |-> s_took)
        else $error("error flag rose without a host word");
    a_loaded_stick: assert property (
        buffer_loaded_flag_q && !loaded_clr |=> buffer_loaded_flag_q)
        else $error("loaded flag fell without a clear");
    a_loaded_source: assert property (
        $rose(buffer_loaded_flag_q) |-> s_took)
        else $error("loaded flag rose without a host word");
    a_pkt_restart: assert property (
        s_end_taken |=> !mac_valid || mac_sop)
        else $error("word after packet end is not a packet start");
endmodule // txu_monitor

// file: tb/txu_host_model.sv
// host model: writes transmit buffers into the unpacker as words
module txu_host_model (
    // clock and reset
    input  logic        mclk,
    input  logic        nrst,
    // pacing: 1 idles one cycle after each taken word
    input  logic        slow,
    // host write stream
    output logic        in_valid = 1'h0,
    output logic [31:0] in_data  = 32'h5A5A5A5A,
    input  logic        in_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] q[$];
    logic        took = 1'h0;

    // handshake seen at the rising edge, acted on at the falling one
    always @(posedge mclk) took <= in_valid && in_ready;

    // idle cycles show the inverse word so stale data cannot pass
    always @(negedge mclk or negedge nrst) begin
        if (!nrst) begin
            in_valid <= 1'h0;
            in_data  <= ~in_data;
        end else begin
            if (took) void'(q.pop_front());
            if (q.size() != 0 && !(slow && took)) begin
                in_valid <= 1'h1;
                in_data  <= q[0];
            end else begin
                in_valid <= 1'h0;
                in_data  <= ~in_data;
            end
        end
    end

    // one buffer: command words, skipped dwords, payload, end padding
    task automatic send_buf(input logic [4:0] off, input logic [10:0] size,
        input logic [1:0] align, input logic first, input logic last,
        input logic done, input logic [31:0] cmdb, input logic [7:0] base);
        int nw, am, idx;
        logic [31:0] w;
        nw = (off + size + 3) / 4;
        am = (align == 2'h2) ? 8 : (align == 2'h1) ? 4 : 1;
        nw = (nw + am - 1) / am * am;
        q.push_back({done, 5'h00, align, 3'h0, off, 2'h0, first, last,
                     1'h0, size});
        if (first) q.push_back(cmdb);
        for (int k = 0; k < nw; k++) begin
            w = 32'hEEEEEEEE;
            for (int j = 0; j < 4; j++) begin
                idx = k * 4 + j - off;
                if (idx >= 0 && idx < size) w[j*8 +: 8] = base + idx[7:0];
            end
            q.push_back(w);
        end
    endtask
endmodule // txu_host_model

// file: tb/testbench.sv
// self-checking bench for the transmit buffer unpacker
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("CHECK FAILED at %0t: got %h expected %h", \
                 $time, got, exp); \
    end \
end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0]  off;
        logic [10:0] size;
        logic [1:0]  align;
        logic [3:0]  ctl;  // checksum, crc off, pad off, global enable
        logic [15:0] tag;
        logic [2:0]  exp;  // checksum, crc off, pad off after decode
    } txu_row_t;
    txu_row_t    rows [6] = '{
        '{5'h00, 11'h005, 2'h0, 4'h9, 16'hA5C3, 3'h4},
        '{5'h01, 11'h004, 2'h1, 4'hC, 16'h0F0F, 3'h2},
        '{5'h02, 11'h009, 2'h2, 4'h7, 16'h8001, 3'h1},
        '{5'h1F, 11'h001, 2'h3, 4'hB, 16'hFFFF, 3'h5},
        '{5'h06, 11'h011, 2'h1, 4'h1, 16'h0001, 3'h0},
        '{5'h0D, 11'h002, 2'h0, 4'hD, 16'h1234, 3'h6}};
    logic        mclk = 1'h0;
    logic        nrst = 1'h0;
    logic        slow = 1'h0;
    logic        mac_ready = 1'h1;
    logic        checksum_offload_global_enable = 1'h0;
    logic        error_clr = 1'h0;
    logic        loaded_clr = 1'h0;
    logic [1:0]  sink_mode = 2'h0;  // ready, stalled, every other cycle
    logic        in_valid, in_ready, mac_valid, mac_sop, mac_eop;
    logic [31:0] in_data, mac_data;
    logic [3:0]  mac_be;
    logic [15:0] pkt_tag_q;
    logic        csum_req_q, crc_add_dis_q, pad_dis_q;
    logic        transmit_error_flag_q, buffer_loaded_flag_q;
    logic [37:0] rx[$], ex[$];
    int          error_cnt = 0;
    int          checks_done = 0;

    always #12.5 mclk = ~mclk;
    // sink pacing lets the payload fifo fill up and drain
    always @(negedge mclk) mac_ready <= (sink_mode == 2'h0) ||
        (sink_mode == 2'h2 && !mac_ready);
    // unused lanes are masked off, their content is free
    always @(posedge mclk) if (nrst && mac_valid && mac_ready)
        rx.push_back({mac_sop, mac_eop, mac_be, mac_data & {{8{mac_be[3]}},
            {8{mac_be[2]}}, {8{mac_be[1]}}, {8{mac_be[0]}}}});

    txu_unpacker txu_unpacker_i (.mclk(mclk), .nrst(nrst),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .mac_valid(mac_valid), .mac_data(mac_data), .mac_be(mac_be),
        .mac_sop(mac_sop), .mac_eop(mac_eop), .mac_ready(mac_ready),
        .pkt_tag_q(pkt_tag_q), .csum_req_q(csum_req_q),
        .crc_add_dis_q(crc_add_dis_q), .pad_dis_q(pad_dis_q),
        .checksum_offload_global_enable(checksum_offload_global_enable),
        .transmit_error_flag_q(transmit_error_flag_q),
        .error_clr(error_clr), .loaded_clr(loaded_clr),
        .buffer_loaded_flag_q(buffer_loaded_flag_q));
    txu_host_model txu_host_model_i (.mclk(mclk), .nrst(nrst), .slow(slow),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready));

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // queue a buffer at the host and its payload words as expectation
    task automatic put(input logic [4:0] off, input logic [10:0] size,
        input logic [1:0] align, input logic f, input logic l,
        input logic d, input logic [31:0] b, input logic [7:0] base);
        int nd, idx;
        logic [31:0] w;
        logic [3:0]  be;
        txu_host_model_i.send_buf(off, size, align, f, l, d, b, base);
        nd = (off[1:0] + size + 3) / 4;
        for (int k = 0; k < nd; k++) begin
            w = 32'h0;
            be = 4'h0;
            for (int j = 0; j < 4; j++) begin
                idx = k * 4 + j - off[1:0];
                if (idx >= 0 && idx < size) begin
                    be[j] = 1'h1;
                    w[j*8 +: 8] = base + idx[7:0];
                end
            end
            ex.push_back({f && k == 0, l && k == nd - 1, be, w});
        end
    endtask

    // wait, bounded, until every expected word came out, then compare
    task automatic drain();
        int n;
        for (n = 0; n < 4000; n++) begin
            if (txu_host_model_i.q.size() == 0 && rx.size() >= ex.size())
                break;
            @(negedge mclk);
        end
        if (n == 4000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: stream stuck", $time);
            conclude();
        end
        repeat (6) @(negedge mclk);
        `CHK(rx.size(), ex.size())
        for (int i = 0; i < ex.size(); i++) `CHK(rx[i], ex[i])
        `CHK(mac_valid, 1'h0)
        rx.delete();
        ex.delete();
    endtask

    initial begin
        repeat (20) @(negedge mclk);
        `CHK({in_ready, mac_valid, transmit_error_flag_q}, 3'h4)
        nrst = 1'h1;
        // single buffer packets: offsets, alignments, control bits
        for (int r = 0; r < 6; r++) begin
            checksum_offload_global_enable = rows[r].ctl[0];
            put(rows[r].off, rows[r].size, rows[r].align, 1'h1, 1'h1, 1'h0,
                {rows[r].tag, 1'h0, rows[r].ctl[3:1], 1'h0, rows[r].size},
                rows[r].tag[7:0]);
            drain();
            `CHK(pkt_tag_q, rows[r].tag)
            `CHK({csum_req_q, crc_add_dis_q, pad_dis_q}, rows[r].exp)
            `CHK(transmit_error_flag_q, 1'h0)
        end
        `CHK(buffer_loaded_flag_q, 1'h0)
        // fragmented packet into a stalled sink, slow host
        sink_mode = 2'h1;
        slow = 1'h1;
        put(5'h07, 11'h04F, 2'h1, 1'h1, 1'h0, 1'h0,
            {16'hBEEF, 5'h00, 11'h06F}, 8'h10);
        put(5'h00, 11'h00F, 2'h1, 1'h0, 1'h0, 1'h0, 32'h0, 8'h60);
        put(5'h0A, 11'h011, 2'h1, 1'h0, 1'h1, 1'h1, 32'h0, 8'h6F);
        repeat (60) @(negedge mclk);
        `CHK(in_ready, 1'h0)
        sink_mode = 2'h2;
        drain();
        `CHK({transmit_error_flag_q, buffer_loaded_flag_q}, 2'h1)
        `CHK(pkt_tag_q, 16'hBEEF)
        sink_mode = 2'h0;
        slow = 1'h0;
        loaded_clr = 1'h1;
        @(negedge mclk);
        loaded_clr = 1'h0;
        `CHK(buffer_loaded_flag_q, 1'h0)
        // a first buffer with no payload is loaded at its second word
        put(5'h00, 11'h000, 2'h0, 1'h1, 1'h1, 1'h1,
            {16'h0006, 5'h00, 11'h000}, 8'h00);
        drain();
        `CHK(buffer_loaded_flag_q, 1'h1)
        // short length, then a good packet back to back
        put(5'h01, 11'h004, 2'h0, 1'h1, 1'h0, 1'h0,
            {16'h0002, 5'h00, 11'h009}, 8'h20);
        put(5'h02, 11'h004, 2'h2, 1'h0, 1'h1, 1'h0, 32'h0, 8'h24);
        put(5'h00, 11'h003, 2'h0, 1'h1, 1'h1, 1'h1,
            {16'h0003, 5'h00, 11'h003}, 8'h30);
        drain();
        `CHK(transmit_error_flag_q, 1'h1)
        `CHK({buffer_loaded_flag_q, pkt_tag_q}, 17'h10003)
        error_clr = 1'h1;
        @(negedge mclk);
        error_clr = 1'h0;
        `CHK(transmit_error_flag_q, 1'h0)
        // a middle buffer with no packet open is flagged
        put(5'h00, 11'h004, 2'h0, 1'h0, 1'h0, 1'h0, 32'h0, 8'h70);
        drain();
        `CHK(transmit_error_flag_q, 1'h1)
        // reset in mid packet, then traffic resumes
        put(5'h00, 11'h040, 2'h0, 1'h1, 1'h1, 1'h0,
            {16'h0004, 5'h00, 11'h040}, 8'h40);
        repeat (8) @(negedge mclk);
        nrst = 1'h0;
        txu_host_model_i.q.delete();
        @(negedge mclk);
        `CHK({in_ready, mac_valid, pkt_tag_q}, 18'h20000)
        rx.delete();
        ex.delete();
        nrst = 1'h1;
        put(5'h03, 11'h006, 2'h1, 1'h1, 1'h1, 1'h0,
            {16'h0005, 5'h00, 11'h006}, 8'h50);
        drain();
        `CHK(transmit_error_flag_q, 1'h0)
        conclude();
    end
endmodule // testbench

bind txu_unpacker txu_monitor txu_monitor_i (.mclk(mclk), .nrst(nrst),
    .in_valid(in_valid), .in_ready(in_ready), .mac_valid(mac_valid),
    .mac_data(mac_data), .mac_be(mac_be), .mac_sop(mac_sop),
    .mac_eop(mac_eop), .mac_ready(mac_ready), .pkt_tag_q(pkt_tag_q),
    .csum_req_q(csum_req_q), .crc_add_dis_q(crc_add_dis_q),
    .pad_dis_q(pad_dis_q),
    .checksum_offload_global_enable(checksum_offload_global_enable),
    .transmit_error_flag_q(transmit_error_flag_q), .error_clr(error_clr),
    .buffer_loaded_flag_q(buffer_loaded_flag_q), .loaded_clr(loaded_clr));
